// ---- inc/rts_regs.svh ----
// register offsets, field positions, reset values and timing counts of the reset sequencer
// assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef RTS_REGS_SVH
`define RTS_REGS_SVH

// byte offsets on the register bus
`define RTS_ADDR_POWER_STATUS   8'h00
`define RTS_ADDR_RESET_STATUS   8'h04
`define RTS_ADDR_RETAINED       8'h08
`define RTS_ADDR_CONTROL        8'h0c

// power_status fields, both flags active low
`define RTS_PS_BROWNOUT_BIT     0
`define RTS_PS_POWERON_BIT      1
// reset_status fields (read only)
`define RTS_RS_TIMEOUT_BIT      0
`define RTS_RS_POWERDOWN_BIT    1
`define RTS_RS_CORE_RESET_BIT   2
`define RTS_RS_PIN_LOW_BIT      3
// control fields
`define RTS_CTL_SLEEP_BIT       0

`define RTS_RETAINED_RESET      32'h0000_0000

// oscillator_select encodings
`define RTS_OSC_RC              2'h3
`define RTS_OSC_HSPD            2'h2
`define RTS_OSC_MED             2'h1
`define RTS_OSC_LOWP            2'h0

`define RTS_RESP_OKAY           2'h0
`define RTS_RESP_SLVERR         2'h2

// timing
`define RTS_CLK_NS              8
`define RTS_PUP_MS              72
`define RTS_PUP_CYCLES          ((`RTS_PUP_MS * 1000000) / `RTS_CLK_NS)
`define RTS_XSTART_CYCLES       1024
`define RTS_LOW_MIN_NS          100000
`define RTS_LOW_MIN_CYCLES      ((`RTS_LOW_MIN_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)
`define RTS_PIN_FILT_NS         2000
`define RTS_PIN_FILT_CYCLES     ((`RTS_PIN_FILT_NS + `RTS_CLK_NS - 1) / `RTS_CLK_NS)

`endif

// ---- inc/rts_pkg.sv ----
// types shared by the reset sequencer and its bench
// assumes rts_regs.svh for all numeric constants
`default_nettype none
package rts_pkg;

  typedef enum logic [2:0] {
    RTS_ST_POR,
    RTS_ST_LOW_HOLD,
    RTS_ST_PUP,
    RTS_ST_XSTART,
    RTS_ST_RUN
  } rts_state_t;

  // configuration word bits
  typedef struct packed {
    logic       brownout_enable_cfg;
    logic       powerup_timer_enable_cfg;
    logic [1:0] oscillator_select;
  } rts_cfg_t;

  // one-cycle event pulses from same-clock logic
  typedef struct packed {
    logic watchdog_reset;
    logic watchdog_wake;
    logic interrupt_wake;
  } rts_evt_t;

  typedef struct packed {
    rts_state_t  st;
    logic [23:0] tmr;
    logic [10:0] start_cnt;
    logic [23:0] bo_cnt;
    logic [23:0] pin_cnt;
    logic        pin_low;
    logic        pin_s1;
    logic        pin_s2;
    logic        bo_s1;
    logic        bo_s2;
    logic        por_s1;
    logic        por_s2;
    logic        osc_s1;
    logic        osc_s2;
    logic        osc_s3;
    logic        power_up_timer_done;
    logic        power_up_timer_done_r1;
    logic        power_up_timer_done_r2;
    logic        start_due;
    logic        brownout_flag;
    logic        poweron_flag;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic        sleep;
    logic [31:0] retained;
    logic        core_reset;
    logic        reset_load;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rts_regs_t;

endpackage
`default_nettype wire

// ---- src/rts_sequencer.sv ----
// reset sequencer: merges reset sources, runs the power-up and start-up delays,
// keeps the reset-cause flags and serves them over AXI4-Lite
// assumes pin and detector inputs are asynchronous; event pulses come from clk logic
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`include "rts_regs.svh"
`default_nettype none

module rts_sequencer #(
  parameter int unsigned PUP_CYCLES      = `RTS_PUP_CYCLES,
  parameter int unsigned XSTART_CYCLES   = `RTS_XSTART_CYCLES,
  parameter int unsigned LOW_MIN_CYCLES  = `RTS_LOW_MIN_CYCLES,
  parameter int unsigned PIN_FILT_CYCLES = `RTS_PIN_FILT_CYCLES
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // reset sources
  input  wire logic             power_on_pulse,
  input  wire logic             external_reset_pin_n,
  input  wire logic             supply_below_threshold,
  input  wire logic             main_oscillator_input,
  input  wire rts_pkg::rts_evt_t evt,
  input  wire rts_pkg::rts_cfg_t cfg,
  // reset outputs
  output logic                  core_reset,
  output logic                  reset_load,
  output logic                  timeout_flag,
  output logic                  powerdown_flag,
  // axi4-lite write
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import rts_pkg::*;

  rts_regs_t q;
  rts_regs_t n;

  logic raw_low;
  logic pin_assert;
  logic bo_low;
  logic brownout_evt;
  logic osc_rise;
  logic power_up_timer_on;
  logic xtal;
  logic wr_go;
  logic rd_go;

  always_comb begin
    raw_low      = !q.pin_s2;
    // a pin change counts only once it has been stable for the filter time
    pin_assert   = raw_low && !q.pin_low &&
                   (q.pin_cnt == 24'(PIN_FILT_CYCLES - 1));
    bo_low       = q.bo_s2 && cfg.brownout_enable_cfg;
    // "longer than" the minimum: trips one cycle past the minimum count
    brownout_evt = bo_low && (q.bo_cnt == 24'(LOW_MIN_CYCLES));
    osc_rise     = q.osc_s2 && !q.osc_s3;
    power_up_timer_on      = !cfg.powerup_timer_enable_cfg || cfg.brownout_enable_cfg;
    xtal         = cfg.oscillator_select != `RTS_OSC_RC;
    wr_go        = q.awready && s_axi_awvalid && s_axi_wvalid;
    rd_go        = q.arready && s_axi_arvalid;
  end

  always_comb begin
    n = q;
    n.reset_load = 1'b0;
    n.power_up_timer_done  = 1'b0;

    // two-flop synchronisers; the first stage feeds only the second
    n.pin_s1 = external_reset_pin_n;
    n.pin_s2 = q.pin_s1;
    n.bo_s1  = supply_below_threshold;
    n.bo_s2  = q.bo_s1;
    n.por_s1 = power_on_pulse;
    n.por_s2 = q.por_s1;
    n.osc_s1 = main_oscillator_input;
    n.osc_s2 = q.osc_s1;
    n.osc_s3 = q.osc_s2;

    // reset pin noise filter
    if (raw_low != q.pin_low) begin
      if (q.pin_cnt == 24'(PIN_FILT_CYCLES - 1)) begin
        n.pin_low = raw_low;
        n.pin_cnt = 24'h000000;
      end else begin
        n.pin_cnt = q.pin_cnt + 24'h000001;
      end
    end else begin
      n.pin_cnt = 24'h000000;
    end

    // brown-out duration counter, saturates once tripped
    if (!bo_low) begin
      n.bo_cnt = 24'h000000;
    end else if (q.bo_cnt != 24'(LOW_MIN_CYCLES) + 24'h000001) begin
      n.bo_cnt = q.bo_cnt + 24'h000001;
    end

    // completion retimed so a late timer edge cannot race the start-up count
    n.power_up_timer_done_r1 = q.power_up_timer_done;
    n.power_up_timer_done_r2 = q.power_up_timer_done_r1;

    case (q.st)
      RTS_ST_POR: begin
        if (cfg.brownout_enable_cfg) begin
          n.st = RTS_ST_LOW_HOLD;
        end else if (power_up_timer_on) begin
          n.st  = RTS_ST_PUP;
          n.tmr = 24'h000000;
        end else if (xtal && q.start_due) begin
          n.st        = RTS_ST_XSTART;
          n.start_cnt = 11'h000;
        end else begin
          n.st = RTS_ST_RUN;
        end
      end
      RTS_ST_LOW_HOLD: begin
        if (!bo_low) begin
          n.st  = RTS_ST_PUP;
          n.tmr = 24'h000000;
        end
      end
      RTS_ST_PUP: begin
        if (bo_low) begin
          n.st  = RTS_ST_LOW_HOLD;
          n.tmr = 24'h000000;
        end else if (q.power_up_timer_done_r2) begin
          if (xtal && q.start_due) begin
            n.st        = RTS_ST_XSTART;
            n.start_cnt = 11'h000;
          end else begin
            n.st = RTS_ST_RUN;
          end
        end else if (q.tmr == 24'(PUP_CYCLES - 1)) begin
          // timer holds its final count while completion is retimed
          n.power_up_timer_done = !q.power_up_timer_done_r1 && !q.power_up_timer_done_r2;
        end else begin
          n.tmr = q.tmr + 24'h000001;
        end
      end
      RTS_ST_XSTART: begin
        if (osc_rise) begin
          if (q.start_cnt == 11'(XSTART_CYCLES - 1)) begin
            n.st = RTS_ST_RUN;
          end else begin
            n.start_cnt = q.start_cnt + 11'h001;
          end
        end
      end
      RTS_ST_RUN: begin
        n.st = RTS_ST_RUN;
      end
      default: begin
        n.st = RTS_ST_POR;
      end
    endcase

    // software writes go first so that a hardware flag event in the same cycle wins
    n.awready = 1'b0;
    n.wready  = 1'b0;
    if (s_axi_awvalid && s_axi_wvalid && !q.awready && !q.bvalid) begin
      n.awready = 1'b1;
      n.wready  = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.bvalid = 1'b1;
      n.bresp  = `RTS_RESP_OKAY;
      case (s_axi_awaddr)
        `RTS_ADDR_POWER_STATUS: begin
          if (s_axi_wstrb[0]) begin
            n.brownout_flag = s_axi_wdata[`RTS_PS_BROWNOUT_BIT];
            n.poweron_flag  = s_axi_wdata[`RTS_PS_POWERON_BIT];
          end
        end
        `RTS_ADDR_RETAINED: begin
          for (int i = 0; i < 4; i++) begin
            if (s_axi_wstrb[i]) begin
              n.retained[8*i +: 8] = s_axi_wdata[8*i +: 8];
            end
          end
        end
        `RTS_ADDR_CONTROL: begin
          if (s_axi_wstrb[0]) begin
            n.sleep = s_axi_wdata[`RTS_CTL_SLEEP_BIT];
          end
        end
        `RTS_ADDR_RESET_STATUS: begin
          n.bresp = `RTS_RESP_OKAY;
        end
        default: begin
          n.bresp = `RTS_RESP_SLVERR;
        end
      endcase
    end

    n.arready = s_axi_arvalid && !q.arready && !q.rvalid;
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (rd_go) begin
      n.rvalid = 1'b1;
      n.rresp  = `RTS_RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        `RTS_ADDR_POWER_STATUS: begin
          n.rdata[`RTS_PS_BROWNOUT_BIT] = q.brownout_flag;
          n.rdata[`RTS_PS_POWERON_BIT]  = q.poweron_flag;
        end
        `RTS_ADDR_RESET_STATUS: begin
          n.rdata[`RTS_RS_TIMEOUT_BIT]    = q.timeout_flag;
          n.rdata[`RTS_RS_POWERDOWN_BIT]  = q.powerdown_flag;
          n.rdata[`RTS_RS_CORE_RESET_BIT] = q.core_reset;
          n.rdata[`RTS_RS_PIN_LOW_BIT]    = q.pin_low;
        end
        `RTS_ADDR_RETAINED: begin
          n.rdata = q.retained;
        end
        `RTS_ADDR_CONTROL: begin
          n.rdata[`RTS_CTL_SLEEP_BIT] = q.sleep;
        end
        default: begin
          n.rresp = `RTS_RESP_SLVERR;
        end
      endcase
    end

    // reset sources by priority; the retained word is never touched here
    if (q.por_s2) begin
      n.st             = RTS_ST_POR;
      n.timeout_flag   = 1'b1;
      n.powerdown_flag = 1'b1;
      n.poweron_flag   = 1'b0;
      if (cfg.brownout_enable_cfg) begin
        n.brownout_flag = 1'b1;
      end
      n.start_due  = 1'b1;
      n.sleep      = 1'b0;
      n.reset_load = 1'b1;
    end else if (brownout_evt) begin
      n.st             = RTS_ST_LOW_HOLD;
      n.timeout_flag   = 1'b1;
      n.powerdown_flag = 1'b1;
      n.brownout_flag  = 1'b0;
      n.start_due      = 1'b1;
      n.sleep          = 1'b0;
      n.reset_load     = 1'b1;
    end else if (evt.watchdog_reset && !q.sleep) begin
      // internal only: this block has no drive onto the reset pin
      n.timeout_flag   = 1'b0;
      n.powerdown_flag = 1'b1;
      n.reset_load     = 1'b1;
      if (cfg.brownout_enable_cfg) begin
        n.st        = RTS_ST_LOW_HOLD;
        n.start_due = 1'b0;
      end
    end else if (pin_assert) begin
      n.reset_load = 1'b1;
      if (q.sleep) begin
        n.timeout_flag   = 1'b1;
        n.powerdown_flag = 1'b0;
        n.sleep          = 1'b0;
        n.start_due      = 1'b1;
        n.st             = cfg.brownout_enable_cfg ? RTS_ST_LOW_HOLD :
                           (xtal ? RTS_ST_XSTART : RTS_ST_RUN);
        n.start_cnt      = 11'h000;
      end else if (cfg.brownout_enable_cfg) begin
        n.st        = RTS_ST_LOW_HOLD;
        n.start_due = 1'b0;
      end
    end else if (q.sleep && (evt.watchdog_wake || evt.interrupt_wake)) begin
      // wake-up resumes execution: no reset load
      n.timeout_flag   = !evt.watchdog_wake;
      n.powerdown_flag = 1'b0;
      n.sleep          = 1'b0;
      n.start_cnt      = 11'h000;
      if (xtal) begin
        n.st = RTS_ST_XSTART;
      end
    end

    // pin low holds the core but never stalls the delays
    n.core_reset = (n.st != RTS_ST_RUN) || n.pin_low;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q                <= '0;
      q.st             <= RTS_ST_POR;
      q.pin_s1         <= 1'b1;
      q.pin_s2         <= 1'b1;
      q.timeout_flag   <= 1'b1;
      q.powerdown_flag <= 1'b1;
      q.brownout_flag  <= 1'b1;
      q.start_due      <= 1'b1;
      q.core_reset     <= 1'b1;
      q.retained       <= `RTS_RETAINED_RESET;
    end else begin
      q <= n;
    end
  end

  assign core_reset     = q.core_reset;
  assign reset_load     = q.reset_load;
  assign timeout_flag   = q.timeout_flag;
  assign powerdown_flag = q.powerdown_flag;
  assign s_axi_awready  = q.awready;
  assign s_axi_wready   = q.wready;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_bvalid   = q.bvalid;
  assign s_axi_arready  = q.arready;
  assign s_axi_rdata    = q.rdata;
  assign s_axi_rresp    = q.rresp;
  assign s_axi_rvalid   = q.rvalid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_wake_only;
    q.sleep && evt.watchdog_wake && !q.por_s2 && !brownout_evt && !pin_assert;
  endsequence

  sequence s_wake_result;
    !q.reset_load && !q.timeout_flag && !q.powerdown_flag;
  endsequence

  a_core_held: assert property (q.st != RTS_ST_RUN |-> q.core_reset)
    else $error("core reset released before sequence finished");
  a_por_flags: assert property (q.por_s2 |=> q.timeout_flag && q.powerdown_flag
                                && !q.poweron_flag && q.reset_load)
    else $error("power-on flags wrong");
  a_rc_no_start: assert property ((q.st == RTS_ST_PUP && n.st == RTS_ST_XSTART)
                                  |-> cfg.oscillator_select != `RTS_OSC_RC)
    else $error("start-up count entered in rc mode");
  a_pup_full_len: assert property ((q.st == RTS_ST_PUP && n.st != RTS_ST_PUP
                                    && n.st != RTS_ST_LOW_HOLD && !q.por_s2)
                                   |-> q.tmr == 24'(PUP_CYCLES - 1))
    else $error("power-up timer ended early");
  a_start_full_len: assert property ((q.st == RTS_ST_XSTART && n.st == RTS_ST_RUN)
                                     |-> osc_rise
                                         && q.start_cnt == 11'(XSTART_CYCLES - 1))
    else $error("start-up count ended early");
  a_low_restart: assert property ((q.st == RTS_ST_PUP && bo_low && !q.por_s2 && !q.sleep)
                                  |=> q.st == RTS_ST_LOW_HOLD && q.tmr == 24'h000000)
    else $error("brown-out did not restart power-up timer");
  a_wake_no_load: assert property (s_wake_only |=> s_wake_result)
    else $error("watchdog wake-up loaded reset state");
  a_brown_flags: assert property ((brownout_evt && !q.por_s2)
                                  |=> !q.brownout_flag && q.timeout_flag
                                      && q.powerdown_flag)
    else $error("brown-out flag code wrong");
  a_rc_no_delay: assert property ((q.st == RTS_ST_POR && !q.por_s2 && !q.sleep
                                   && cfg == 4'b0111 && !evt.watchdog_reset)
                                  |=> q.st == RTS_ST_RUN)
    else $error("delay applied in rc mode with timer off");
  a_pin_filtered: assert property ($rose(q.pin_low)
                                   |-> $past(q.pin_cnt) == 24'(PIN_FILT_CYCLES - 1)
                                       && $past(raw_low))
    else $error("reset pin pulse passed filter early");

endmodule
`default_nettype wire

// ---- verification/rts_supply_model.sv ----
// far side of the sequencer: power-on pulse, reset pin, supply detector, crystal
// assumes the bench raises the requests; only the crystal runs asynchronous to clk, the other outputs follow the requests directly
`default_nettype none
module rts_supply_model (
  // requests from the bench
  input  wire logic por_req,
  input  wire logic pin_req,
  input  wire logic dip_req,
  // device pins
  output logic      power_on_pulse,
  output logic      external_reset_pin_n,
  output logic      supply_below_threshold,
  output logic      main_oscillator_input
);
  timeunit 1ns;
  timeprecision 1ps;
  assign power_on_pulse = por_req;
  // pull-up on the pin, so a released pin reads high
  assign external_reset_pin_n = !pin_req;
  assign supply_below_threshold = dip_req;
  // crystal runs free with a phase unrelated to clk
  initial begin
    main_oscillator_input = 1'b0;
    #3;
    forever #16 main_oscillator_input = !main_oscillator_input;
  end
endmodule
`default_nettype wire

// ---- verification/reset_timeout_sequencer_tb.sv ----
// self-checking bench for the reset sequencer
// assumes rts_pkg, rts_regs.svh and rts_supply_model are compiled first
`include "rts_regs.svh"
`default_nettype none
module reset_timeout_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rts_pkg::*;
  typedef struct packed {
    rts_cfg_t    cfg;
    logic [15:0] lo;
    logic [15:0] hi;
  } rts_row_t;
  // crystal modes cost 4096 clk for the start-up count at a 32 ns oscillator
  rts_row_t    rows [6] = '{'{4'h0, 16'h1011, 16'h1036}, '{4'h5, 16'h0ffa, 16'h100e},
                            '{4'ha, 16'h1011, 16'h1036}, '{4'h3, 16'h0015, 16'h0023},
                            '{4'hf, 16'h0015, 16'h0023}, '{4'h7, 16'h0001, 16'h000a}};
  // {event, pin, sleep, timeout, powerdown, load seen}
  logic [7:0]  evs [5] = '{8'h83, 8'h13, 8'h2c, 8'h48, 8'h1d};
  logic        clk, sys_rst, por_req, pin_req, dip_req, ld;
  logic        core_reset, reset_load, timeout_flag, powerdown_flag;
  wire         pon, pin_n, below, osc;
  rts_evt_t    evt;
  rts_cfg_t    cfg;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          err_count, comparisons, t;

  rts_supply_model sup_u (.por_req(por_req), .pin_req(pin_req), .dip_req(dip_req),
    .power_on_pulse(pon), .external_reset_pin_n(pin_n),
    .supply_below_threshold(below), .main_oscillator_input(osc));
  rts_sequencer #(.PUP_CYCLES(20), .LOW_MIN_CYCLES(5), .PIN_FILT_CYCLES(4)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .power_on_pulse(pon), .external_reset_pin_n(pin_n),
    .supply_below_threshold(below), .main_oscillator_input(osc), .evt(evt), .cfg(cfg),
    .core_reset(core_reset), .reset_load(reset_load), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("mismatches=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // leading edge keeps a strobe from being written twice in one time step
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
    do @(posedge clk); while (awready !== 1'b1 || wready !== 1'b1);
    {awvalid, wvalid} <= 2'h0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    rsp = bresp;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'h3};
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    {rd, rsp} = {rdata, rresp};
  endtask
  task automatic wait_free();
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (core_reset !== 1'b0 && t < 9000);
  endtask
  // records whether any reset activity shows over n cycles
  task automatic quiet(input int n);
    ld = 1'b0;
    repeat (n) begin
      @(posedge clk);
      ld |= core_reset | reset_load;
    end
  endtask

  initial begin
    // the whole run takes roughly 13000 cycles; this stays well under the limit
    #400us;
    err_count++;
    complete_run();
  end

  initial begin
    {sys_rst, por_req, pin_req, dip_req} = 4'h8;
    evt = '0;
    cfg = 4'h7;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
    err_count = 0;
    comparisons = 0;
    cyc(5);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(32'({core_reset, timeout_flag, powerdown_flag, bvalid, rvalid}), 32'h1c);
    foreach (rows[i]) begin
      axw(`RTS_ADDR_POWER_STATUS, 32'h3);
      cfg <= rows[i].cfg;
      por_req <= 1'b1;
      cyc(8);
      chk(32'(core_reset), 32'h1);
      por_req <= 1'b0;
      wait_free();
      chk(32'(t >= rows[i].lo && t <= rows[i].hi), 32'h1);
      chk(32'({timeout_flag, powerdown_flag}), 32'h3);
      axr(`RTS_ADDR_POWER_STATUS);
      chk(rd, 32'h1);
    end
    axw(`RTS_ADDR_RETAINED, 32'h5aa5_c33c);
    foreach (evs[i]) begin
      if (evs[i][3]) begin
        axw(`RTS_ADDR_CONTROL, 32'h1);
      end
      evt <= evs[i][7:5];
      pin_req <= evs[i][4];
      @(posedge clk);
      evt <= '0;
      ld = 1'b0;
      repeat (24) begin
        @(posedge clk);
        ld |= reset_load;
      end
      pin_req <= 1'b0;
      cyc(16);
      chk(32'({timeout_flag, powerdown_flag, ld}), 32'(evs[i][2:0]));
      chk(32'(core_reset), 32'h0);
    end
    axr(`RTS_ADDR_RETAINED);
    chk(rd, 32'h5aa5_c33c);
    pin_req <= 1'b1;
    cyc(2);
    pin_req <= 1'b0;
    dip_req <= 1'b1;
    quiet(16);
    dip_req <= 1'b0;
    chk(32'(ld), 32'h0);
    axw(`RTS_ADDR_POWER_STATUS, 32'h3);
    cfg <= 4'hf;
    dip_req <= 1'b1;
    cyc(3);
    dip_req <= 1'b0;
    quiet(12);
    chk(32'(ld), 32'h0);
    repeat (2) begin
      dip_req <= 1'b1;
      cyc(16);
      chk(32'(core_reset), 32'h1);
      dip_req <= 1'b0;
      cyc(8);
    end
    wait_free();
    chk(32'(t >= 13 && t <= 27), 32'h1);
    axr(`RTS_ADDR_POWER_STATUS);
    chk(rd, 32'h2);
    axw(`RTS_ADDR_RESET_STATUS, 32'h0);
    axr(`RTS_ADDR_RESET_STATUS);
    chk(rd, 32'h3);
    axr(8'h10);
    chk({rd[29:0], rsp}, 32'h2);
    complete_run();
  end
endmodule
`default_nettype wire
